// >>> src/goc_correct.sv
// Gain and offset correction of filtered samples, with offset calibration.
// Assumes samples and host writes are synchronous to i_sys_clk; the host
// keeps the shift exponent within range and drains the output stream.
//
// Operation
// RULE_01 - Gain and offset registers take and hold any signed 24-bit value, including the most negative.
// RULE_02 - With gain correction on, each sample is multiplied by the gain register over 0x7fffff.
// RULE_03 - With offset correction on, each sample has the offset register subtracted from it.
// RULE_04 - The calibration enable starts the offset calibration loop, weighted by the shift exponent.
// RULE_05 - The exponent is programmed 0x00 to 0x18 and acts as a power-of-two shift of the feedback.
// RULE_06 - While calibrating, each new calibration result is written into the offset register.
// RULE_07 - With calibration off, the last offset result stays in the register untouched.
// RULE_08 - With both on, offset is subtracted first, then gain applied, and the result saturates.
`timescale 1ns/100ps

module goc_correct (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst,
  // Host register writes and readback
  input  wire logic        i_gain_wr,
  input  wire logic [23:0] i_gain_wr_data,
  input  wire logic        i_offset_wr,
  input  wire logic [23:0] i_offset_wr_data,
  output logic      [23:0] o_gain_value,
  output logic      [23:0] o_offset_value,
  // Control bits
  input  wire logic        i_gain_correct_enable,
  input  wire logic        i_offset_correct_enable,
  input  wire logic        i_offset_cal_enable,
  input  wire logic [4:0]  i_cal_shift_exponent,
  // Incoming filtered samples
  input  wire logic        i_smp_valid,
  input  wire logic [23:0] i_smp_data,
  output logic             o_smp_ready,
  // Corrected samples
  output logic             o_out_valid,
  output logic [23:0]      o_out_data,
  input  wire logic        i_out_ready
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // True when a wide signed value does not fit the signed 24-bit range
  function automatic logic ovf24(input logic signed [48:0] v);
    return (v[48:23] != {26{v[48]}});
  endfunction

  // Clamp a wide signed value into the signed 24-bit range; one clamp
  // serves both the output path and the calibration sum
  function automatic logic [23:0] sat24(input logic signed [48:0] v);
    logic [23:0] r;
    r = v[23:0];
    if (ovf24(v)) begin
      r = v[48] ? goc_pkg::SAT_NEG : goc_pkg::SAT_POS;
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic        [23:0] gain_q;
  logic        [23:0] offset_q;
  logic        [23:0] offset_d;
  logic        [23:0] buf_mem_q [2];
  logic               wr_ptr_q;
  logic               rd_ptr_q;
  logic        [1:0]  count_q;
  logic               accept;
  logic               pop;
  logic signed [24:0] smp_ext;
  logic signed [24:0] off_ext;
  logic signed [24:0] diff_w;
  logic signed [48:0] prod_w;
  logic signed [48:0] quot_w;
  logic signed [48:0] unity_w;
  logic signed [48:0] scaled_w;
  logic               sat_hit;
  logic        [23:0] push_data;
  logic        [4:0]  exp_eff;
  logic signed [24:0] cal_diff;
  logic signed [24:0] cal_step;
  logic signed [24:0] cal_sum;
  logic        [23:0] cal_result;

  ////////////////////////////////////////////////////////////////////////////
  // Correction datapath

  // Offset first, then gain; one saturation at the end
  assign smp_ext   = {i_smp_data[23], i_smp_data};
  assign off_ext   = {offset_q[23], offset_q};
  assign diff_w    = i_offset_correct_enable ? (smp_ext - off_ext) : smp_ext; // RULE_03
  assign unity_w   = $signed({25'h0000000, goc_pkg::GAIN_UNITY});
  assign prod_w    = diff_w * $signed(gain_q);
  // Exact division keeps full-scale gain a true unity, at some area cost
  assign quot_w    = prod_w / unity_w; // RULE_02
  // Full quotient width kept: a most-negative gain can push the result
  // past 25 bits, and a narrower cut would wrap before the clamp
  assign scaled_w  = i_gain_correct_enable ? quot_w : 49'(diff_w); // RULE_08
  assign sat_hit   = ovf24(scaled_w);
  assign push_data = sat24(scaled_w); // RULE_08

  ////////////////////////////////////////////////////////////////////////////
  // Offset calibration

  // Out-of-range exponents are clamped so the shift stays bounded
  assign exp_eff    = (i_cal_shift_exponent > goc_pkg::EXP_MAX) ?
                      goc_pkg::EXP_MAX : i_cal_shift_exponent; // RULE_05
  assign cal_diff   = smp_ext - off_ext;
  assign cal_step   = cal_diff >>> exp_eff; // RULE_05
  assign cal_sum    = off_ext + cal_step; // RULE_04
  assign cal_result = sat24(49'(cal_sum));

  // Host write wins over a calibration step in the same cycle
  assign offset_d = i_offset_wr ? i_offset_wr_data :
                    (i_offset_cal_enable && accept) ? cal_result : // RULE_06
                    offset_q; // RULE_07

  ////////////////////////////////////////////////////////////////////////////
  // Correction registers

  // Gain and offset storage, full signed range
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      gain_q   <= goc_pkg::GAIN_RST;
      offset_q <= goc_pkg::OFFSET_RST;
    end else begin
      if (i_gain_wr) begin
        gain_q <= i_gain_wr_data; // RULE_01
      end
      offset_q <= offset_d; // RULE_01
    end
  end

  assign o_gain_value   = gain_q;
  assign o_offset_value = offset_q;

  ////////////////////////////////////////////////////////////////////////////
  // Two-entry output buffer

  // A stalled receiver stalls intake, so no sample is dropped
  assign o_smp_ready = (count_q != goc_pkg::BUF_DEPTH);
  assign accept      = i_smp_valid && o_smp_ready;
  assign o_out_valid = (count_q != 2'h0);
  assign pop         = o_out_valid && i_out_ready;
  assign o_out_data  = buf_mem_q[rd_ptr_q];

  // Buffer storage written at the tail
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      buf_mem_q[0] <= 24'h000000;
      buf_mem_q[1] <= 24'h000000;
    end else if (accept) begin
      buf_mem_q[wr_ptr_q] <= push_data;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      count_q  <= 2'h0;
    end else begin
      wr_ptr_q <= wr_ptr_q ^ accept;
      rd_ptr_q <= rd_ptr_q ^ pop;
      count_q  <= count_q + {1'b0, accept} - {1'b0, pop};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  property p_gain_wr;
    @(posedge i_sys_clk) disable iff (i_rst)
      i_gain_wr |=> (gain_q == $past(i_gain_wr_data));
  endproperty
  a_gain_wr: assert property (p_gain_wr) else $error("gain write lost"); // RULE_01

  property p_gain_hold;
    @(posedge i_sys_clk) disable iff (i_rst)
      !i_gain_wr |=> $stable(gain_q);
  endproperty
  a_gain_hold: assert property (p_gain_hold) else $error("gain not held"); // RULE_01

  property p_offset_wr;
    @(posedge i_sys_clk) disable iff (i_rst)
      i_offset_wr |=> (offset_q == $past(i_offset_wr_data));
  endproperty
  a_offset_wr: assert property (p_offset_wr) else $error("offset write lost"); // RULE_01

  property p_gain_unity;
    @(posedge i_sys_clk) disable iff (i_rst)
      accept && i_gain_correct_enable && !i_offset_correct_enable &&
      (gain_q == goc_pkg::GAIN_UNITY) |=> (buf_mem_q[$past(wr_ptr_q)] == $past(i_smp_data));
  endproperty
  a_gain_unity: assert property (p_gain_unity) else $error("unity gain alters data"); // RULE_02

  property p_offset_sub;
    @(posedge i_sys_clk) disable iff (i_rst)
      accept && i_offset_correct_enable && !i_gain_correct_enable &&
      (diff_w[24] == diff_w[23])
      |=> (buf_mem_q[$past(wr_ptr_q)] == ($past(i_smp_data) - $past(offset_q)));
  endproperty
  a_offset_sub: assert property (p_offset_sub) else $error("offset not subtracted"); // RULE_03

  property p_cal_exp0;
    @(posedge i_sys_clk) disable iff (i_rst)
      accept && i_offset_cal_enable && !i_offset_wr && (i_cal_shift_exponent == 5'h00)
      |=> (offset_q == $past(i_smp_data));
  endproperty
  a_cal_exp0: assert property (p_cal_exp0) else $error("cal result not stored"); // RULE_06

  // A sample equal to the offset leaves the calibration settled
  property p_cal_fixed;
    @(posedge i_sys_clk) disable iff (i_rst)
      accept && i_offset_cal_enable && !i_offset_wr && (i_smp_data == offset_q)
      |=> $stable(offset_q);
  endproperty
  a_cal_fixed: assert property (p_cal_fixed) else $error("settled cal moved"); // RULE_04

  property p_cal_slow;
    @(posedge i_sys_clk) disable iff (i_rst)
      accept && i_offset_cal_enable && !i_offset_wr && (i_cal_shift_exponent == 5'h18) &&
      (i_smp_data == 24'h7fffff) && (offset_q == 24'h000000)
      |=> (offset_q == 24'h000000);
  endproperty
  a_cal_slow: assert property (p_cal_slow) else $error("shift 0x18 not applied"); // RULE_05

  property p_cal_start;
    @(posedge i_sys_clk) disable iff (i_rst)
      accept && i_offset_cal_enable && !i_offset_wr && (i_cal_shift_exponent == 5'h01) &&
      (i_smp_data == 24'h000100) && (offset_q == 24'h000000)
      |=> (offset_q == 24'h000080);
  endproperty
  a_cal_start: assert property (p_cal_start) else $error("cal step wrong"); // RULE_04

  property p_cal_hold;
    @(posedge i_sys_clk) disable iff (i_rst)
      !i_offset_cal_enable && !i_offset_wr |=> $stable(offset_q);
  endproperty
  a_cal_hold: assert property (p_cal_hold) else $error("offset moved"); // RULE_07

  property p_sat_pos;
    @(posedge i_sys_clk) disable iff (i_rst)
      accept && i_offset_correct_enable && !i_smp_data[23] && offset_q[23]
      && !i_gain_correct_enable |=> !buf_mem_q[$past(wr_ptr_q)][23];
  endproperty
  a_sat_pos: assert property (p_sat_pos) else $error("result wrapped"); // RULE_08

  property p_sat_neg;
    @(posedge i_sys_clk) disable iff (i_rst)
      accept && i_offset_correct_enable && i_smp_data[23] && !offset_q[23]
      && !i_gain_correct_enable |=> buf_mem_q[$past(wr_ptr_q)][23];
  endproperty
  a_sat_neg: assert property (p_sat_neg) else $error("result wrapped low"); // RULE_08

  // Worst corner: most-negative gain on the widest difference
  property p_gain_ovf;
    @(posedge i_sys_clk) disable iff (i_rst)
      accept && i_gain_correct_enable && i_offset_correct_enable &&
      (gain_q == goc_pkg::SAT_NEG) && (offset_q == goc_pkg::SAT_NEG) &&
      (i_smp_data == goc_pkg::SAT_POS)
      |=> (buf_mem_q[$past(wr_ptr_q)] == goc_pkg::SAT_NEG);
  endproperty
  a_gain_ovf: assert property (p_gain_ovf) else $error("scaled result wrapped"); // RULE_08

  property p_gain_zero;
    @(posedge i_sys_clk) disable iff (i_rst)
      accept && i_gain_correct_enable && (gain_q == 24'h000000)
      |=> (buf_mem_q[$past(wr_ptr_q)] == 24'h000000);
  endproperty
  a_gain_zero: assert property (p_gain_zero) else $error("zero gain leaks"); // RULE_02

  property p_pass_thru;
    @(posedge i_sys_clk) disable iff (i_rst)
      accept && !i_gain_correct_enable && !i_offset_correct_enable
      |=> (buf_mem_q[$past(wr_ptr_q)] == $past(i_smp_data));
  endproperty
  a_pass_thru: assert property (p_pass_thru) else $error("raw sample altered"); // RULE_03

  property p_out_stall;
    @(posedge i_sys_clk) disable iff (i_rst)
      o_out_valid && !i_out_ready |=> o_out_valid && $stable(o_out_data);
  endproperty
  a_out_stall: assert property (p_out_stall) else $error("stalled word lost");

  // A word taken into an empty buffer shows on the next cycle
  property p_first_word;
    @(posedge i_sys_clk) disable iff (i_rst)
      accept && !o_out_valid |=> o_out_valid;
  endproperty
  a_first_word: assert property (p_first_word) else $error("word not presented");

  property p_cnt_legal;
    @(posedge i_sys_clk) disable iff (i_rst)
      (count_q <= goc_pkg::BUF_DEPTH);
  endproperty
  a_cnt_legal: assert property (p_cnt_legal) else $error("buffer overfilled");

  c_buf_full:  cover property (@(posedge i_sys_clk) disable iff (i_rst) !o_smp_ready);
  c_cal_step:  cover property (@(posedge i_sys_clk) disable iff (i_rst)
                               accept && i_offset_cal_enable);
  c_both_on:   cover property (@(posedge i_sys_clk) disable iff (i_rst)
                               accept && i_offset_correct_enable && i_gain_correct_enable);
  c_saturated: cover property (@(posedge i_sys_clk) disable iff (i_rst)
                               accept && sat_hit);
  c_cal_hold:  cover property (@(posedge i_sys_clk) disable iff (i_rst)
                               accept && !i_offset_cal_enable && i_offset_correct_enable);

endmodule // goc_correct

// >>> src/goc_pkg.sv
// Package of constants for the gain and offset correction stage.
// Assumes 24-bit two's complement samples and one 250 MHz system clock.
package goc_pkg;

  // Sample and coefficient widths
  localparam int unsigned SMP_W = 24;
  localparam int unsigned EXP_W = 5;

  // Gain of unity; scaling divides by this code
  localparam logic [23:0] GAIN_UNITY = 24'h7fffff;

  // Signed 24-bit limits used for saturation
  localparam logic [23:0] SAT_POS = 24'h7fffff;
  localparam logic [23:0] SAT_NEG = 24'h800000;

  // Largest legal calibration shift exponent
  localparam logic [4:0] EXP_MAX = 5'h18;

  // Reset values of the correction registers
  localparam logic [23:0] GAIN_RST   = 24'h7fffff;
  localparam logic [23:0] OFFSET_RST = 24'h000000;

  // Output buffer depth (two entries)
  localparam logic [1:0] BUF_DEPTH = 2'h2;

endpackage : goc_pkg

// >>> verification/goc_correct_tb_top.sv
// Self-checking bench for the gain and offset correction stage.
// Assumes goc_pkg and goc_correct are compiled first; one 250 MHz clock.
`timescale 1ns/100ps

module goc_correct_tb_top;
  logic        i_sys_clk, i_rst, gwr, owr, ge, oe, ce, sv, st;
  logic [23:0] gd, od, sd;
  logic [4:0]  ex;
  wire logic [23:0] gv, ov, odat;
  wire logic        srdy, ovld, ordy;
  int          mismatches, checks, cyc;

  goc_correct i_dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_gain_wr(gwr),
    .i_gain_wr_data(gd), .i_offset_wr(owr), .i_offset_wr_data(od), .o_gain_value(gv),
    .o_offset_value(ov), .i_gain_correct_enable(ge), .i_offset_correct_enable(oe),
    .i_offset_cal_enable(ce), .i_cal_shift_exponent(ex), .i_smp_valid(sv),
    .i_smp_data(sd), .o_smp_ready(srdy), .o_out_valid(ovld), .o_out_data(odat),
    .i_out_ready(ordy));
  goc_sink i_sink (.i_sys_clk(i_sys_clk), .i_stall(st), .i_valid(ovld), .i_data(odat),
    .o_ready(ordy));

  // Clock and a hang guard well beyond the roughly 800 cycles needed
  initial begin
    i_sys_clk = 1'b0;
    forever #2 i_sys_clk = ~i_sys_clk;
  end
  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      mismatches++;
      results();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Reference correction, saturating instead of wrapping
  function automatic logic [23:0] fx(input logic [23:0] s, o, g, input logic oen, gen);
    logic signed [49:0] d;
    d = oen ? $signed(s) - $signed(o) : $signed(s);
    if (gen) d = d * $signed(g) / 50'sd8388607;
    if (d > 50'sd8388607) return goc_pkg::SAT_POS;
    if (d < -50'sd8388608) return goc_pkg::SAT_NEG;
    return d[23:0];
  endfunction
  task chk(input logic [23:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task results;
    if (mismatches == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Both registers written in one strobe cycle
  task wr(input logic [23:0] g, o);
    @(negedge i_sys_clk) {gwr, owr, gd, od} = {2'b11, g, o};
    @(negedge i_sys_clk) {gwr, owr} = 2'b00;
  endtask
  // Sample held until the buffer shows a free entry
  task send(input logic [23:0] s);
    @(negedge i_sys_clk) {sv, sd} = {1'b1, s};
    #1;
    while (srdy !== 1'b1) begin
      @(negedge i_sys_clk) #1;
    end
    @(negedge i_sys_clk) sv = 1'b0;
  endtask
  task rx(input logic [23:0] exp);
    logic [23:0] got;
    got = 24'hxxxxxx;
    repeat (3) @(negedge i_sys_clk);
    if (i_sink.rx_q.size() > 0) got = i_sink.rx_q.pop_front();
    chk(got, exp);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task t_regs;
    chk(gv, goc_pkg::GAIN_RST);
    chk(ov, goc_pkg::OFFSET_RST);
    wr(24'h800000, 24'h800000);
    chk(gv, 24'h800000);
    chk(ov, 24'h800000);
  endtask
  // All four enable combinations, both saturation ends
  task t_modes;
    logic [23:0] smp[3] = '{24'h123456, 24'h800000, 24'h7fffff};
    logic [23:0] off[3] = '{24'h000100, 24'hffff00, 24'h800000};
    logic [23:0] gn[4]  = '{24'h400000, 24'h7fffff, 24'h800000, 24'h000000};
    foreach (gn[j]) begin
      foreach (off[k]) begin
        wr(gn[j], off[k]);
        for (int m = 0; m < 4; m++) begin
          {ge, oe} = m[1:0];
          foreach (smp[i]) begin
            send(smp[i]);
            rx(fx(smp[i], off[k], gn[j], oe, ge));
          end
        end
      end
    end
  endtask
  // Receiver stall: two words held, intake ready low when full, third sent after release, order kept
  task t_buf;
    {ge, oe} = 2'b00;
    st = 1'b1;
    send(24'h00000a);
    send(24'h00000b);
    #1;
    chk({23'h0, srdy}, 24'h0);
    chk({23'h0, ovld}, 24'h1);
    chk(odat, 24'h00000a);
    @(negedge i_sys_clk) st = 1'b0;
    send(24'h00000c);
    rx(24'h00000a);
    rx(24'h00000b);
    rx(24'h00000c);
    chk({23'h0, ovld}, 24'h0);
  endtask
  // Calibration steps, exponent at both ends, then hold after disable
  task t_cal;
    wr(24'h7fffff, 24'h000000);
    {ge, oe, ce, ex} = {3'b011, goc_pkg::EXP_MAX};
    send(24'h7fffff);
    rx(24'h7fffff);
    chk(ov, 24'h000000);
    ex = 5'h01;
    send(24'h000100);
    rx(24'h000100);
    chk(ov, 24'h000080);
    ex = goc_pkg::EXP_MAX;
    send(24'h800000);
    rx(goc_pkg::SAT_NEG);
    chk(ov, 24'h00007f);
    ex = 5'h00;
    send(24'h123456);
    rx(24'h1233d7);
    chk(ov, 24'h123456);
    send(24'h123456);
    rx(24'h000000);
    chk(ov, 24'h123456);
    ce = 1'b0;
    send(24'h000400);
    rx(24'hedcfaa);
    chk(ov, 24'h123456);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {i_rst, gwr, owr, ge, oe, ce, sv, st} = 8'h80;
    {gd, od, sd, ex} = '0;
    repeat (5) @(negedge i_sys_clk);
    i_rst = 1'b0;
    t_regs();
    t_modes();
    t_buf();
    t_cal();
    results();
  end
endmodule // goc_correct_tb_top

// >>> verification/goc_sink.sv
// Receiver model standing after the corrected sample stream.
// Assumes the bench drives i_stall just after the falling clock edge.
`timescale 1ns/100ps

module goc_sink (
  input  wire logic        i_sys_clk,
  input  wire logic        i_stall,
  input  wire logic        i_valid,
  input  wire logic [23:0] i_data,
  output logic             o_ready
);
  logic [23:0] rx_q[$];

  // Stall holds ready low so the two-entry buffer must keep its words
  assign o_ready = !i_stall;

  // Take each word handed over at a rising edge, in arrival order
  always @(posedge i_sys_clk) begin
    if (i_valid && o_ready) begin
      rx_q.push_back(i_data);
    end
  end
endmodule // goc_sink
